/* design/angle_sensor_defs.svh */
// constants for the angle sensor power sequencer and serial target
`ifndef ANGLE_SENSOR_DEFS_SVH
`define ANGLE_SENSOR_DEFS_SVH
`define AS_ANGLE_W 16
`define AS_CFG_W 16
`define AS_BIT_W 4
`define AS_MSB_IDX 4'hf
`define AS_SYS_CLK_MHZ 50
`define AS_LP_TICK_NS 1000
`define AS_LP_TICK_CYC ((`AS_LP_TICK_NS * `AS_SYS_CLK_MHZ) / 1000)
`define AS_SETTLE_NS 2000
`define AS_SETTLE_CYC ((`AS_SETTLE_NS * `AS_SYS_CLK_MHZ + 999) / 1000)
`define AS_CNT_W 16
`endif

/* design/angle_sensor_pkg.sv */
// types shared by the angle sensor power sequencer
package angle_sensor_pkg;
  typedef enum logic [2:0] {
    MODE_IDLE = 3'h1,
    MODE_ACTIVE = 3'h2,
    MODE_AUTO = 3'h4
  } power_mode_t;
endpackage

/* design/angle_sensor_power_and_spi.sv */
// power-mode sequencer and spi target front end of the angle sensor
`timescale 1ns/100ps
`include "angle_sensor_defs.svh"

module angle_sensor_power_and_spi #(
  parameter logic [`AS_CNT_W-1:0] SETTLE_CYC = `AS_CNT_W'(`AS_SETTLE_CYC)
) (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // mode pins
  input wire logic wake_pin,
  input wire logic auto_cycle_select,
  // front end samples
  input wire logic [`AS_ANGLE_W-1:0] angle_in,
  input wire logic angle_strobe,
  // configuration
  input wire logic [`AS_CFG_W-1:0] active_time,
  input wire logic [`AS_CFG_W-1:0] cycle_period,
  input wire logic [`AS_ANGLE_W-1:0] change_threshold,
  input wire logic [`AS_ANGLE_W-1:0] ref_angle,
  // status
  output logic front_end_en,
  output logic settled_flag,
  output logic new_sample_flag,
  output angle_sensor_pkg::power_mode_t power_mode,
  // spi target
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic [`AS_ANGLE_W-1:0] rx_word,
  output logic rx_word_valid
);
  import angle_sensor_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [`AS_ANGLE_W-1:0] abs_diff(input logic [`AS_ANGLE_W-1:0] a,
                                                       input logic [`AS_ANGLE_W-1:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // system domain state
  typedef struct packed {
    logic [1:0] wake_sync;
    logic [1:0] auto_sync;
    logic [1:0] cs_sync;
    logic [1:0] tgl_sync;
    logic cs_seen;
    logic tgl_seen;
    power_mode_t mode;
    logic [`AS_CNT_W-1:0] tick_cnt;
    logic [`AS_CFG_W-1:0] cyc_cnt;
    logic [`AS_CNT_W-1:0] settle_cnt;
    logic fe_en;
    logic settled;
    logic new_sample;
    logic [`AS_ANGLE_W-1:0] out_buf;
    logic [`AS_ANGLE_W-1:0] rx_word;
    logic rx_valid;
  } sys_state_t;

  sys_state_t s_r;
  sys_state_t s_nxt;
  logic cs_low;
  logic cs_fall;
  logic auto_on;
  logic lp_tick;
  logic active_end;
  logic frame_done;
  power_mode_t mode_sel;

  // spi domain state, one struct per clock edge and reset source
  typedef struct packed {
    logic seen_rise;
    logic [`AS_ANGLE_W-1:0] shift;
    logic [`AS_BIT_W:0] nbits;
  } rise_state_t;

  // kept apart: must outlive chip select, cleared only by system reset
  typedef struct packed {
    logic [`AS_ANGLE_W-1:0] word;
    logic done_tgl;
  } word_state_t;

  typedef struct packed {
    logic [`AS_BIT_W-1:0] idx;
  } fall_state_t;

  rise_state_t r_r;
  rise_state_t r_nxt;
  word_state_t w_r;
  word_state_t w_nxt;
  fall_state_t f_r;
  fall_state_t f_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.wake_sync = {s_r.wake_sync[0], wake_pin};
    s_nxt.auto_sync = {s_r.auto_sync[0], auto_cycle_select};
    s_nxt.cs_sync = {s_r.cs_sync[0], spi_cs_n};
    s_nxt.tgl_sync = {s_r.tgl_sync[0], w_r.done_tgl};
    s_nxt.cs_seen = s_r.cs_sync[1];
    s_nxt.tgl_seen = s_r.tgl_sync[1];
    cs_low = ~s_r.cs_sync[1];
    cs_fall = s_r.cs_seen & ~s_r.cs_sync[1];
    frame_done = s_r.tgl_sync[1] ^ s_r.tgl_seen;
    // wake wins over auto-cycle; both low rests in idle
    if (s_r.wake_sync[1]) begin
      mode_sel = MODE_ACTIVE;
    end else if (s_r.auto_sync[1]) begin
      mode_sel = MODE_AUTO;
    end else begin
      mode_sel = MODE_IDLE;
    end
    s_nxt.mode = mode_sel;
    auto_on = (s_r.mode == MODE_AUTO);
    // low-power tick times the automatic cycle
    lp_tick = (s_r.tick_cnt == `AS_CNT_W'(`AS_LP_TICK_CYC - 1));
    active_end = 1'b0;
    if (!auto_on) begin
      s_nxt.tick_cnt = '0;
      s_nxt.cyc_cnt = '0;
    end else if (lp_tick) begin
      s_nxt.tick_cnt = '0;
      if (s_r.cyc_cnt + `AS_CFG_W'(1) >= cycle_period) begin
        s_nxt.cyc_cnt = '0;
      end else begin
        s_nxt.cyc_cnt = s_r.cyc_cnt + `AS_CFG_W'(1);
      end
      active_end = (s_r.cyc_cnt + `AS_CFG_W'(1) == active_time);
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + `AS_CNT_W'(1);
    end
    // front end powered only in active or the on-phase of the cycle
    case (s_r.mode)
      MODE_ACTIVE: s_nxt.fe_en = 1'b1;
      MODE_AUTO: s_nxt.fe_en = (s_nxt.cyc_cnt < active_time);
      MODE_IDLE: s_nxt.fe_en = 1'b0;
      default: s_nxt.fe_en = 1'b0;
    endcase
    // filter settling restarts whenever the front end was off
    if (!s_r.fe_en) begin
      s_nxt.settle_cnt = '0;
      s_nxt.settled = 1'b0;
    end else if (s_r.settle_cnt >= SETTLE_CYC) begin
      s_nxt.settled = 1'b1;
    end else begin
      s_nxt.settle_cnt = s_r.settle_cnt + `AS_CNT_W'(1);
    end
    // buffer frozen while a frame is open; idle keeps the last angle
    if (!cs_low) begin
      if (s_r.mode == MODE_ACTIVE && angle_strobe && s_r.fe_en) begin
        s_nxt.out_buf = angle_in;
      end else if (auto_on && active_end) begin
        s_nxt.out_buf = angle_in;
      end
    end
    // start of a read clears, a new event in the same cycle wins
    if (cs_fall) begin
      s_nxt.new_sample = 1'b0;
    end
    if (auto_on && active_end) begin
      if (change_threshold == '0) begin
        s_nxt.new_sample = 1'b1;
      end else if (abs_diff(angle_in, ref_angle) > change_threshold) begin
        s_nxt.new_sample = 1'b1;
      end
    end
    s_nxt.rx_valid = frame_done;
    if (frame_done) begin
      s_nxt.rx_word = w_r.word;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{wake_sync: 2'h0, auto_sync: 2'h0, cs_sync: 2'h3, tgl_sync: 2'h0,
               cs_seen: 1'b1, tgl_seen: 1'b0, mode: MODE_IDLE, tick_cnt: '0,
               cyc_cnt: '0, settle_cnt: '0, fe_en: 1'b0, settled: 1'b0,
               new_sample: 1'b0, out_buf: '0, rx_word: '0, rx_valid: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // spi domain: chip select high clears the frame, so only the word state needs the system reset
  always_comb begin
    r_nxt = r_r;
    w_nxt = w_r;
    r_nxt.seen_rise = 1'b1;
    r_nxt.shift = {r_r.shift[`AS_ANGLE_W-2:0], spi_mosi};
    if (r_r.nbits == 5'(`AS_ANGLE_W - 1)) begin
      r_nxt.nbits = '0;
      w_nxt.word = {r_r.shift[`AS_ANGLE_W-2:0], spi_mosi};
      w_nxt.done_tgl = ~w_r.done_tgl;
    end else begin
      r_nxt.nbits = r_r.nbits + 5'(1);
    end
  end

  // edge driven only, so any clock rate works
  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      r_r <= '{seen_rise: 1'b0, shift: '0, nbits: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  // word and toggle survive chip select so the system side can fetch them
  always_ff @(posedge spi_sclk or negedge rst_n) begin
    if (!rst_n) begin
      w_r <= '{word: '0, done_tgl: 1'b0};
    end else if (!spi_cs_n) begin
      w_r <= w_nxt;
    end
  end

  // a leading falling edge in mode 3 comes before any rising edge: ignored
  always_comb begin
    f_nxt = f_r;
    if (r_r.seen_rise) begin
      f_nxt.idx = f_r.idx - `AS_BIT_W'(1);
    end
  end

  always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      f_r <= '{idx: `AS_MSB_IDX};
    end else begin
      f_r <= f_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; miso gated by chip select since mode 0 has no edge before the msb
  assign front_end_en = s_r.fe_en;
  assign settled_flag = s_r.settled;
  assign new_sample_flag = s_r.new_sample;
  assign power_mode = s_r.mode;
  assign rx_word = s_r.rx_word;
  assign rx_word_valid = s_r.rx_valid;
  assign spi_miso = ~spi_cs_n & s_r.out_buf[f_r.idx];

  ////////////////////////////////////////////////////////////////////////////
  sequence s_wake_held;
    wake_pin [*3];
  endsequence

  property p_wake_active;
    @(posedge sys_clk) disable iff (!rst_n) s_wake_held |=> power_mode == MODE_ACTIVE;
  endproperty
  a_wake_active: assert property (p_wake_active) else $error("wake gave no active");

  property p_auto_mode;
    @(posedge sys_clk) disable iff (!rst_n)
      (!wake_pin && auto_cycle_select) [*3] |=> power_mode == MODE_AUTO;
  endproperty
  a_auto_mode: assert property (p_auto_mode) else $error("auto pin did not give auto");

  property p_idle_mode;
    @(posedge sys_clk) disable iff (!rst_n)
      (!wake_pin && !auto_cycle_select) [*3] |=> power_mode == MODE_IDLE;
  endproperty
  a_idle_mode: assert property (p_idle_mode) else $error("no pins did not give idle");

  property p_idle_fe_off;
    @(posedge sys_clk) disable iff (!rst_n)
      power_mode == MODE_IDLE [*3] |-> !front_end_en && !settled_flag;
  endproperty
  a_idle_fe_off: assert property (p_idle_fe_off) else $error("front end on in idle");

  property p_settled_cause;
    @(posedge sys_clk) disable iff (!rst_n) $rose(settled_flag) |-> $past(front_end_en, 2);
  endproperty
  a_settled_cause: assert property (p_settled_cause) else $error("settled unpowered");

  property p_buf_auto;
    @(posedge sys_clk) disable iff (!rst_n)
      s_r.mode == MODE_AUTO && !active_end |=> $stable(s_r.out_buf);
  endproperty
  a_buf_auto: assert property (p_buf_auto) else $error("buffer loaded mid cycle");

  property p_ns_set;
    @(posedge sys_clk) disable iff (!rst_n)
      auto_on && active_end && change_threshold == '0 |=> new_sample_flag;
  endproperty
  a_ns_set: assert property (p_ns_set) else $error("new sample not raised");

  property p_ns_clear;
    @(posedge sys_clk) disable iff (!rst_n) cs_fall && !active_end |=> !new_sample_flag;
  endproperty
  a_ns_clear: assert property (p_ns_clear) else $error("new sample not cleared");

  property p_buf_frozen;
    @(posedge sys_clk) disable iff (!rst_n) cs_low |=> $stable(s_r.out_buf);
  endproperty
  a_buf_frozen: assert property (p_buf_frozen) else $error("buffer moved in frame");

  property p_miso_idle;
    @(posedge sys_clk) disable iff (!rst_n) spi_cs_n |-> !spi_miso;
  endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("miso driven idle");

  property p_settled_drop;
    @(posedge sys_clk) disable iff (!rst_n) !front_end_en |=> !settled_flag;
  endproperty
  a_settled_drop: assert property (p_settled_drop) else $error("settled kept");

  property p_active_fe;
    @(posedge sys_clk) disable iff (!rst_n) power_mode == MODE_ACTIVE |=> front_end_en;
  endproperty
  a_active_fe: assert property (p_active_fe) else $error("front end off in active");

  property p_rx_pulse;
    @(posedge sys_clk) disable iff (!rst_n) rx_word_valid |=> !rx_word_valid;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("frame strobe too long");
endmodule

/* dv/spi_host.sv */
// spi host model facing the sensor's serial target
`timescale 1ns/100ps
module spi_host (
  // serial pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  logic lclk = 1'b0;
  always #3 lclk = ~lclk;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // one frame in mode 0 or 3; half period of 24 ns keeps sclk under 25 mhz
  task automatic xfer(input logic m3, input logic [15:0] tx, output logic [15:0] rx);
    int i;
    @(posedge lclk);
    sclk <= m3;
    repeat (25) @(posedge lclk);
    cs_n <= 1'b0;
    mosi <= tx[15];
    repeat (25) @(posedge lclk);
    for (i = 0; i < 16; i++) begin
      if (i > 0 || m3) begin
        sclk <= 1'b0;
        mosi <= tx[15-i];
      end
      repeat (4) @(posedge lclk);
      sclk <= 1'b1;
      repeat (4) @(posedge lclk);
      rx[15-i] = miso;
    end
    // clock back to its idle level before deselect
    sclk <= m3;
    repeat (4) @(posedge lclk);
    cs_n <= 1'b1;
    // released line must not keep the last bit
    mosi <= ~mosi;
    repeat (25) @(posedge lclk);
  endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the angle sensor power sequencer and serial target
`timescale 1ns/100ps
module testbench;
  import angle_sensor_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wake_pin = 1'b0;
  logic auto_cycle_select = 1'b0;
  logic angle_strobe = 1'b0;
  logic [15:0] angle_in = 16'h0000;
  logic [15:0] active_time = 16'h0002;
  logic [15:0] cycle_period = 16'h0004;
  logic [15:0] change_threshold = 16'h0000;
  logic [15:0] ref_angle = 16'h0000;
  logic front_end_en, settled_flag, new_sample_flag, rx_word_valid;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso;
  logic [15:0] rx_word, a, rx;
  power_mode_t power_mode;
  int n_mismatch = 0;
  int checks = 0;
  int n_rx = 0;
  int n;
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (rx_word_valid === 1'b1) n_rx++;
  angle_sensor_power_and_spi #(.SETTLE_CYC(16'h0004)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .wake_pin(wake_pin), .auto_cycle_select(auto_cycle_select), .angle_in(angle_in),
    .angle_strobe(angle_strobe), .active_time(active_time), .cycle_period(cycle_period),
    .change_threshold(change_threshold), .ref_angle(ref_angle), .front_end_en(front_end_en),
    .settled_flag(settled_flag), .new_sample_flag(new_sample_flag), .power_mode(power_mode),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .rx_word(rx_word), .rx_word_valid(rx_word_valid));
  spi_host u_host (.sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi), .miso(spi_miso));
  ////////////////////////////////////////////////////////////
  function int fe_high_cycles(input logic [15:0] at);
    return at * 50;
  endfunction
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // mode visible only on the third edge after the pins move
  task mode_to(input logic w_in, input logic a_in, input power_mode_t m);
    power_mode_t old;
    old = power_mode;
    @(posedge sys_clk);
    wake_pin <= w_in;
    auto_cycle_select <= a_in;
    repeat (2) @(posedge sys_clk);
    #1 check(16'(power_mode), 16'(old));
    repeat (2) @(posedge sys_clk);
    #1 check(16'(power_mode), 16'(m));
  endtask
  task strobe(input logic [15:0] v);
    @(posedge sys_clk);
    angle_in <= v;
    angle_strobe <= 1'b1;
    @(posedge sys_clk);
    angle_strobe <= 1'b0;
  endtask
  // random command frame; checks angle out, frame in and idle miso
  task spi_read(input logic m3, input logic [15:0] exp);
    logic [15:0] tx;
    int n0;
    tx = 16'($urandom);
    // store and restore waits would outlast the run
    if (tx[15:13] > 3'h4) tx[15:13] = 3'h4;
    n0 = n_rx;
    u_host.xfer(m3, tx, rx);
    check(rx, exp);
    check(rx_word, tx);
    check(16'(n_rx - n0), 16'h0001);
    check(16'(spi_miso), 16'h0000);
  endtask
  task wait_flag;
    int k;
    for (k = 0; k < 3000 && new_sample_flag !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    check(16'(new_sample_flag), 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    void'($urandom(87));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 check(16'(power_mode), 16'(MODE_IDLE));
    check(16'({front_end_en, settled_flag, new_sample_flag}), 16'h0000);
    mode_to(1'b1, 1'b0, MODE_ACTIVE);
    check(16'({front_end_en, settled_flag}), 16'h0002);
    repeat (8) @(posedge sys_clk);
    #1 check(16'(settled_flag), 16'h0001);
    for (int j = 0; j < 3; j++) begin
      a = 16'($urandom);
      strobe(a);
      spi_read(j[0], a);
    end
    mode_to(1'b0, 1'b0, MODE_IDLE);
    // settled follows the front end one edge later
    @(posedge sys_clk);
    #1 check(16'({front_end_en, settled_flag}), 16'h0000);
    strobe(~a);
    spi_read(1'b1, a);
    a = 16'($urandom) & 16'h7fff;
    strobe(a);
    mode_to(1'b0, 1'b1, MODE_AUTO);
    wait_flag;
    // a strobe in auto mode must not reach the buffer
    strobe(a ^ 16'h0f0f);
    spi_read(1'b0, a);
    check(16'(new_sample_flag), 16'h0000);
    n = 0;
    repeat (200) begin
      @(posedge sys_clk);
      #1 if (front_end_en === 1'b1) n++;
    end
    check(16'(n), 16'(fe_high_cycles(active_time)));
    mode_to(1'b1, 1'b1, MODE_ACTIVE);
    mode_to(1'b0, 1'b1, MODE_AUTO);
    @(posedge sys_clk);
    change_threshold <= 16'h0100;
    ref_angle <= a;
    angle_in <= a + 16'h0010;
    u_host.xfer(1'b0, 16'h0000, rx);
    repeat (600) @(posedge sys_clk);
    #1 check(16'(new_sample_flag), 16'h0000);
    spi_read(1'b1, a + 16'h0010);
    @(posedge sys_clk);
    angle_in <= a + 16'h0200;
    wait_flag;
    give_verdict;
  end
endmodule
